/* File: common/rtc_params.svh */
// Constants for the calendar clock: timing, field limits and reset values
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define RTC_CLK_PERIOD_NS 40
`define RTC_SECOND_NS 1000000000
`define RTC_TICK_CYCLES (`RTC_SECOND_NS / `RTC_CLK_PERIOD_NS)
`define RTC_BATT_LOSS_S 15
`define RTC_BOOT_CYCLES 3

`define RTC_DATA_W 16
`define RTC_HHMMSS_W 18
`define RTC_YEAR_W 14
`define RTC_MONTH_W 4
`define RTC_DATE_W 5
`define RTC_DOW_W 3
`define RTC_HOUR_W 5
`define RTC_MIN_W 6
`define RTC_SEC_W 6

`define RTC_SEC_MAX 59
`define RTC_MIN_MAX 59
`define RTC_HOUR_MAX 23
`define RTC_MONTH_MAX 12
`define RTC_DOW_MAX 7
`define RTC_YEAR_MAX 9999

`define RTC_RST_YEAR 2000
`define RTC_RST_MONTH 1
`define RTC_RST_DATE 1
`define RTC_RST_DOW 6
`define RTC_RST_HOUR 0
`define RTC_RST_MIN 0
`define RTC_RST_SEC 0

`define RTC_HOUR_WEIGHT 10000
`define RTC_MIN_WEIGHT 100

`endif

/* File: common/rtc_pkg.sv */
// Types shared by the calendar clock design
package rtc_pkg;
  typedef enum logic [2:0] {
    sel_year,
    sel_month,
    sel_date,
    sel_dow,
    sel_hour,
    sel_minute,
    sel_second
  } field_sel_type;
endpackage : rtc_pkg

/* File: hdl/field_counter.sv */
// One wrapping calendar field with a program load and a carry out
`timescale 1ns/1ps
`default_nettype none
module field_counter #(
  parameter int W = 6,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic inc,
  input wire logic ld,
  input wire logic [W-1:0] ld_val,
  input wire logic [W-1:0] hi,
  // Value
  output logic [W-1:0] val_ff,
  output logic carry
);
  generate
    if (W < 1 || W > 16) begin : g_bad_width
      $error("field_counter width out of range");
    end
  endgenerate

  // A written value above the top wraps on the next advance
  assign carry = inc && (val_ff >= hi);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      val_ff <= RST;
    end else if (ld) begin
      val_ff <= ld_val;
    end else if (carry) begin
      val_ff <= LO;
    end else if (inc) begin
      val_ff <= val_ff + W'(1);
    end
  end
endmodule : field_counter
`default_nettype wire

/* File: hdl/rtc_calendar_top.sv */
// Calendar clock with optional backed module, fault flag and packed time
//
// Operation
// - Keep year to second, advancing once per second.
// - Seven date and time fields, each readable and writable.
// - Fields held and returned as plain binary integers.
// - Year holds the full four-digit value with century.
// - Day of week runs 1 for Monday up to 7 for Sunday.
// - Detect the backed module and take seconds from it when present.
// - Missing battery or removal beyond 15 seconds means data lost.
// - Lost data sets the fault flag and lights the indicator.
// - Corrupted contents or absent battery also raise the fault.
// - Packed time equals hour*10000 + minute*100 + second.
// - Fault clears after setting and power cycle unless module damaged.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module rtc_calendar_top #(
  parameter int TICK_CYCLES = `RTC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Field write
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [`RTC_DATA_W-1:0] wr_data,
  // Field read
  input wire logic [2:0] rd_sel,
  output logic [`RTC_DATA_W-1:0] rd_data_ff,
  // Packed time
  output logic [`RTC_HHMMSS_W-1:0] hhmmss_ff,
  // Backed module pins
  input wire logic mod_present_in,
  input wire logic mod_tick_in,
  input wire logic mod_batt_ok_in,
  input wire logic mod_corrupt_in,
  // Status
  output logic src_module_ff,
  output logic clk_fault_ff,
  output logic fault_led_ff
);
  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  logic tick_prev_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      tick_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {mod_corrupt_in, mod_batt_ok_in, mod_tick_in, mod_present_in};
      pin_sync_ff <= pin_meta_ff;
      tick_prev_ff <= pin_sync_ff[1];
    end
  end
  logic present_s;
  logic batt_ok_s;
  logic corrupt_s;
  logic mod_edge;
  assign present_s = pin_sync_ff[0];
  assign batt_ok_s = pin_sync_ff[2];
  assign corrupt_s = pin_sync_ff[3];
  assign mod_edge = pin_sync_ff[1] && !tick_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Internal one-second divider
  localparam int DIV_W = $clog2(TICK_CYCLES);
  logic [DIV_W-1:0] div_ff;
  logic int_tick;
  assign int_tick = (div_ff == DIV_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
    end else if (int_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // Seconds come from the module while it is fitted
  logic sec_tick;
  assign sec_tick = src_module_ff ? mod_edge : int_tick;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      src_module_ff <= 1'b0;
    end else begin
      src_module_ff <= present_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar fields
  logic [`RTC_YEAR_W-1:0] year_v;
  logic [`RTC_MONTH_W-1:0] month_v;
  logic [`RTC_DATE_W-1:0] date_v;
  logic [`RTC_DOW_W-1:0] dow_v;
  logic [`RTC_HOUR_W-1:0] hour_v;
  logic [`RTC_MIN_W-1:0] min_v;
  logic [`RTC_SEC_W-1:0] sec_v;
  logic c_sec, c_min, c_hour, c_date, c_month;
  logic [6:0] ld;
  logic [`RTC_DATE_W-1:0] month_days;
  logic leap;

  always_comb begin
    ld = 7'h00;
    if (wr_en && wr_sel <= 3'(rtc_pkg::sel_second)) begin
      ld[wr_sel] = 1'b1;
    end
  end

  // Four-digit year decides the leap day
  assign leap = (year_v % 4 == 0) && ((year_v % 100 != 0) || (year_v % 400 == 0));
  always_comb begin
    case (month_v)
      4'h2: month_days = leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'h1e;
      default: month_days = 5'h1f;
    endcase
  end

  field_counter #(.W(`RTC_SEC_W), .LO('0), .RST(`RTC_SEC_W'(`RTC_RST_SEC))) u_sec (
    .clk_sys(clk_sys), .rst(rst), .inc(sec_tick), .ld(ld[rtc_pkg::sel_second]),
    .ld_val(wr_data[`RTC_SEC_W-1:0]), .hi(`RTC_SEC_W'(`RTC_SEC_MAX)),
    .val_ff(sec_v), .carry(c_sec));
  field_counter #(.W(`RTC_MIN_W), .LO('0), .RST(`RTC_MIN_W'(`RTC_RST_MIN))) u_min (
    .clk_sys(clk_sys), .rst(rst), .inc(c_sec), .ld(ld[rtc_pkg::sel_minute]),
    .ld_val(wr_data[`RTC_MIN_W-1:0]), .hi(`RTC_MIN_W'(`RTC_MIN_MAX)),
    .val_ff(min_v), .carry(c_min));
  field_counter #(.W(`RTC_HOUR_W), .LO('0), .RST(`RTC_HOUR_W'(`RTC_RST_HOUR))) u_hour (
    .clk_sys(clk_sys), .rst(rst), .inc(c_min), .ld(ld[rtc_pkg::sel_hour]),
    .ld_val(wr_data[`RTC_HOUR_W-1:0]), .hi(`RTC_HOUR_W'(`RTC_HOUR_MAX)),
    .val_ff(hour_v), .carry(c_hour));
  field_counter #(.W(`RTC_DATE_W), .LO(`RTC_DATE_W'(1)),
    .RST(`RTC_DATE_W'(`RTC_RST_DATE))) u_date (
    .clk_sys(clk_sys), .rst(rst), .inc(c_hour), .ld(ld[rtc_pkg::sel_date]),
    .ld_val(wr_data[`RTC_DATE_W-1:0]), .hi(month_days),
    .val_ff(date_v), .carry(c_date));
  field_counter #(.W(`RTC_DOW_W), .LO(`RTC_DOW_W'(1)),
    .RST(`RTC_DOW_W'(`RTC_RST_DOW))) u_dow (
    .clk_sys(clk_sys), .rst(rst), .inc(c_hour), .ld(ld[rtc_pkg::sel_dow]),
    .ld_val(wr_data[`RTC_DOW_W-1:0]), .hi(`RTC_DOW_W'(`RTC_DOW_MAX)),
    .val_ff(dow_v), .carry());
  field_counter #(.W(`RTC_MONTH_W), .LO(`RTC_MONTH_W'(1)),
    .RST(`RTC_MONTH_W'(`RTC_RST_MONTH))) u_month (
    .clk_sys(clk_sys), .rst(rst), .inc(c_date), .ld(ld[rtc_pkg::sel_month]),
    .ld_val(wr_data[`RTC_MONTH_W-1:0]), .hi(`RTC_MONTH_W'(`RTC_MONTH_MAX)),
    .val_ff(month_v), .carry(c_month));
  field_counter #(.W(`RTC_YEAR_W), .LO('0), .RST(`RTC_YEAR_W'(`RTC_RST_YEAR))) u_year (
    .clk_sys(clk_sys), .rst(rst), .inc(c_month), .ld(ld[rtc_pkg::sel_year]),
    .ld_val(wr_data[`RTC_YEAR_W-1:0]), .hi(`RTC_YEAR_W'(`RTC_YEAR_MAX)),
    .val_ff(year_v), .carry());

  ////////////////////////////////////////////////////////////////////////////
  // Read port and packed time, both plain binary
  logic [`RTC_DATA_W-1:0] rd_mux;
  always_comb begin
    case (rd_sel)
      3'(rtc_pkg::sel_year): rd_mux = `RTC_DATA_W'(year_v);
      3'(rtc_pkg::sel_month): rd_mux = `RTC_DATA_W'(month_v);
      3'(rtc_pkg::sel_date): rd_mux = `RTC_DATA_W'(date_v);
      3'(rtc_pkg::sel_dow): rd_mux = `RTC_DATA_W'(dow_v);
      3'(rtc_pkg::sel_hour): rd_mux = `RTC_DATA_W'(hour_v);
      3'(rtc_pkg::sel_minute): rd_mux = `RTC_DATA_W'(min_v);
      3'(rtc_pkg::sel_second): rd_mux = `RTC_DATA_W'(sec_v);
      default: rd_mux = '0;
    endcase
  end

  logic [`RTC_HHMMSS_W-1:0] nxt_hhmmss;
  assign nxt_hhmmss = `RTC_HHMMSS_W'(hour_v) * `RTC_HHMMSS_W'(`RTC_HOUR_WEIGHT)
                    + `RTC_HHMMSS_W'(min_v) * `RTC_HHMMSS_W'(`RTC_MIN_WEIGHT)
                    + `RTC_HHMMSS_W'(sec_v);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= '0;
      hhmmss_ff <= '0;
    end else begin
      rd_data_ff <= rd_mux;
      hhmmss_ff <= nxt_hhmmss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault detection
  // Only a reset re-runs the power-up check, so a fault persists until the
  // next power cycle even after software has set the time again.
  logic [1:0] boot_ff;
  logic boot_eval;
  logic [4:0] batt_gone_ff;
  logic batt_lost;
  assign boot_eval = (boot_ff == 2'(`RTC_BOOT_CYCLES - 1));
  assign batt_lost = (batt_gone_ff > 5'(`RTC_BATT_LOSS_S));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_ff <= 2'h0;
    end else if (boot_ff != 2'(`RTC_BOOT_CYCLES)) begin
      boot_ff <= boot_ff + 2'h1;
    end
  end

  // Absence is timed on the internal divider since module ticks may stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      batt_gone_ff <= 5'h00;
    end else if (!present_s || batt_ok_s) begin
      batt_gone_ff <= 5'h00;
    end else if (int_tick && !batt_lost) begin
      batt_gone_ff <= batt_gone_ff + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_fault_ff <= 1'b0;
    end else if (boot_eval && (!present_s || !batt_ok_s || corrupt_s)) begin
      clk_fault_ff <= 1'b1;
    end else if (batt_lost || (present_s && corrupt_s)) begin
      clk_fault_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_led_ff <= 1'b0;
    end else begin
      fault_led_ff <= clk_fault_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sec_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    (sec_tick && sec_v == 6'h3b && !ld[rtc_pkg::sel_second]) |=> sec_v == 6'h00)
    else $error("second did not wrap to zero");
  a_min_carry: assert property (@(posedge clk_sys) disable iff (rst)
    (sec_tick && sec_v == 6'h3b && min_v < 6'h3b && ld == 7'h00)
      |=> min_v == $past(min_v) + 6'h01)
    else $error("minute did not follow second carry");
  a_hour_range: assert property (@(posedge clk_sys) disable iff (rst)
    (c_min && hour_v == 5'h17 && !ld[rtc_pkg::sel_hour]) |=> hour_v == 5'h00)
    else $error("hour did not wrap after 23");
  a_dow_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    (c_hour && dow_v == 3'h7 && !ld[rtc_pkg::sel_dow]) |=> dow_v == 3'h1)
    else $error("sunday did not roll to monday");
  a_read_echo: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_sel == 3'(rtc_pkg::sel_year)) |=> rd_data_ff == `RTC_DATA_W'($past(year_v)))
    else $error("year read does not match field");
  a_packed_time: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> hhmmss_ff == `RTC_HHMMSS_W'($past(hour_v)) * `RTC_HHMMSS_W'(10000)
      + `RTC_HHMMSS_W'($past(min_v)) * `RTC_HHMMSS_W'(100) + `RTC_HHMMSS_W'($past(sec_v)))
    else $error("packed time wrong");
  a_src_select: assert property (@(posedge clk_sys) disable iff (rst)
    (src_module_ff && !mod_edge && !ld[rtc_pkg::sel_second]) |=> sec_v == $past(sec_v))
    else $error("second advanced without module tick");
  a_boot_fault: assert property (@(posedge clk_sys) disable iff (rst)
    (boot_eval && !present_s) |=> clk_fault_ff ##1 fault_led_ff)
    else $error("missing module did not raise fault");
  a_fault_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    clk_fault_ff |=> clk_fault_ff [*3])
    else $error("fault flag dropped without reset");
  a_batt_loss: assert property (@(posedge clk_sys) disable iff (rst)
    (batt_gone_ff == 5'(`RTC_BATT_LOSS_S) && int_tick && present_s && !batt_ok_s)
      |=> ##[1:3] clk_fault_ff)
    else $error("battery loss did not raise fault");
endmodule : rtc_calendar_top
`default_nettype wire

/* File: testbench/tb_rtc_calendar_top.sv */
// Self-checking bench for the calendar clock top, with an integer field model
`timescale 1ns/1ps
`default_nettype none
`include "rtc_params.svh"
module tb_rtc_calendar_top;
  // Short second so rollover and loss timing fit a short run
  localparam int TICKS = 20;
  logic clk_sys, rst, wr_en, mod_present_in, mod_tick_in, mod_batt_ok_in, mod_corrupt_in;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [`RTC_DATA_W-1:0] wr_data;
  logic [`RTC_DATA_W-1:0] rd_data_ff;
  logic [`RTC_HHMMSS_W-1:0] hhmmss_ff;
  logic src_module_ff, clk_fault_ff, fault_led_ff;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h272a6ccf;
  // Model fields, indexed by the select code
  int m[7];
  int yv[7] = '{2023, 12, 31, 7, 23, 59, 58};

  rtc_calendar_top #(.TICK_CYCLES(TICKS)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .rd_sel(rd_sel), .rd_data_ff(rd_data_ff), .hhmmss_ff(hhmmss_ff),
    .mod_present_in(mod_present_in), .mod_tick_in(mod_tick_in),
    .mod_batt_ok_in(mod_batt_ok_in), .mod_corrupt_in(mod_corrupt_in),
    .src_module_ff(src_module_ff), .clk_fault_ff(clk_fault_ff), .fault_led_ff(fault_led_ff)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input int sel, input int val);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_sel <= 3'(sel);
    wr_data <= 16'(val);
    @(posedge clk_sys);
    wr_en <= 1'b0;
    if (sel < 7) begin
      m[sel] = val;
    end
  endtask : wr

  function automatic int dim(input int y, input int mo);
    if (mo == 2) begin
      return ((y % 4 == 0 && y % 100 != 0) || y % 400 == 0) ? 29 : 28;
    end
    return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
  endfunction : dim

  // Held high long enough for the pin synchroniser to see the edge
  task automatic tick;
    @(posedge clk_sys);
    mod_tick_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mod_tick_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    m[6]++;
    if (m[6] == 60) begin
      m[6] = 0;
      m[5]++;
    end
    if (m[5] == 60) begin
      m[5] = 0;
      m[4]++;
    end
    if (m[4] == 24) begin
      m[4] = 0;
      m[2]++;
      m[3] = m[3] % 7 + 1;
    end
    if (m[2] > dim(m[0], m[1])) begin
      m[2] = 1;
      m[1]++;
    end
    if (m[1] == 13) begin
      m[1] = 1;
      m[0]++;
    end
  endtask : tick

  // Only valid while seconds come from the module pin, so nothing moves meanwhile
  task automatic check_all;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      rd_sel <= 3'(i);
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk($sformatf("field %0d", i), 32'(rd_data_ff), (i < 7) ? 32'(m[i]) : 32'h0);
    end
    chk("hhmmss", 32'(hhmmss_ff), 32'(m[4] * 10000 + m[5] * 100 + m[6]));
  endtask : check_all

  task automatic boot(input logic p, input logic b, input logic c);
    @(posedge clk_sys);
    rst <= 1'b1;
    mod_present_in <= p;
    mod_batt_ok_in <= b;
    mod_corrupt_in <= c;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fault", 32'(clk_fault_ff), 32'(!(p && b && !c)));
    chk("led", 32'(fault_led_ff), 32'(!(p && b && !c)));
    chk("source", 32'(src_module_ff), 32'(p));
    m = '{`RTC_RST_YEAR, `RTC_RST_MONTH, `RTC_RST_DATE, `RTC_RST_DOW,
          `RTC_RST_HOUR, `RTC_RST_MIN, `RTC_RST_SEC};
  endtask : boot

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    wr_sel = 3'h0;
    wr_data = 16'h0;
    rd_sel = 3'h0;
    mod_present_in = 1'b1;
    mod_tick_in = 1'b0;
    mod_batt_ok_in = 1'b1;
    mod_corrupt_in = 1'b0;
    // A clean boot comes last, so the runs below start with the flag low
    for (int k = 0; k < 8; k++) begin
      boot(k[2], k[1], !k[0]);
    end
    check_all();
    // Year end on a Sunday rolls every field, writes on alternate cycles first
    for (int i = 0; i < 7; i++) begin
      wr(i, yv[i]);
    end
    wr(7, 5);
    tick();
    tick();
    check_all();
    // Leap day in a four-digit year
    wr(1, 2);
    wr(2, 28);
    wr(4, 23);
    wr(5, 59);
    wr(6, 59);
    tick();
    check_all();
    for (int n = 0; n < 4; n++) begin
      wr(4, {$random(seed)} % 24);
      wr(5, {$random(seed)} % 60);
      // Later rounds sit on second 59, so a random minute takes the carry
      wr(6, (n < 2) ? {$random(seed)} % 60 : 59);
      tick();
      check_all();
    end
    // Battery removed while running: flag only after the fifteen second grace
    @(posedge clk_sys);
    mod_batt_ok_in <= 1'b0;
    repeat (290) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fault early", 32'(clk_fault_ff), 32'h0);
    repeat (50) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fault late", 32'(clk_fault_ff), 32'h1);
    chk("led late", 32'(fault_led_ff), 32'h1);
    boot(1'b1, 1'b1, 1'b0);
    @(posedge clk_sys);
    mod_corrupt_in <= 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fault corrupt", 32'(clk_fault_ff), 32'h1);
    // Internal time base: ten seconds in two hundred cycles, one of slack for latency
    boot(1'b0, 1'b0, 1'b0);
    wr(6, 0);
    rd_sel <= 3'h6;
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("internal secs", 32'(rd_data_ff >= 9 && rd_data_ff <= 11), 32'h1);
    give_verdict();
  end
endmodule : tb_rtc_calendar_top
`default_nettype wire
